// *** hw/mcuic_pkg.sv ***
package mcuic_pkg;
	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_ENABLE  = 8'h04;
	localparam logic [7:0] OFS_FLAGS   = 8'h08;
	localparam logic [7:0] OFS_PSC_A   = 8'h0C;
	localparam logic [7:0] OFS_PSC_B   = 8'h10;
	localparam logic [7:0] OFS_TB_A    = 8'h14;
	localparam logic [7:0] OFS_TB_B    = 8'h18;
	localparam logic [7:0] OFS_VECTOR  = 8'h1C;

	// ----------------------------------------------------------------
	// source indices, lowest index = lowest vector = highest priority
	// ----------------------------------------------------------------
	localparam int NSRC       = 7;
	localparam int SRC_EXT    = 0;
	localparam int SRC_TOUCH  = 1;
	localparam int SRC_CTA    = 2;
	localparam int SRC_PT     = 3;
	localparam int SRC_TBA    = 4;
	localparam int SRC_TBB    = 5;
	localparam int SRC_GRP    = 6;

	// ----------------------------------------------------------------
	// flag register bit positions
	// ----------------------------------------------------------------
	localparam int FB_CTA_A   = 2;
	localparam int FB_CTA_P   = 3;
	localparam int FB_PT_A    = 4;
	localparam int FB_PT_P    = 5;
	localparam int FB_CTB_A   = 8;
	localparam int FB_CTB_P   = 9;
	localparam int NFLAG      = 10;
	localparam int FB_TOUCH   = 1;
	localparam int FB_EXT     = 0;
	localparam int FB_TBA     = 6;
	localparam int FB_TBB     = 7;

	// ----------------------------------------------------------------
	// fields and reset values
	// ----------------------------------------------------------------
	localparam int CTRL_GIE   = 0;
	localparam int TB_ON_BIT  = 7;
	localparam logic [1:0]  EDGE_OFF   = 2'h0;
	localparam logic [1:0]  EDGE_RISE  = 2'h1;
	localparam logic [1:0]  EDGE_FALL  = 2'h2;
	localparam logic [1:0]  EDGE_BOTH  = 2'h3;
	localparam logic [1:0]  PSC_SYS    = 2'h0;
	localparam logic [1:0]  PSC_SYS4   = 2'h1;
	localparam int          TB_MIN_EXP = 8;
	localparam int          TB_CNT_W   = 15;
	localparam logic [7:0]  RST_BYTE   = 8'h00;
	localparam int          VEC_STEP   = 4;
	localparam logic [1:0]  DIV4_LAST  = 2'h3;

	typedef struct packed {
		logic        push;
		logic        pop;
		logic [11:0] vector;
	} mcuic_core_s;
endpackage

// *** hw/mcuic_timebase.sv ***
`timescale 1ns/1ps
module mcuic_timebase (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       srst,
	// configuration
	input  wire logic [1:0] source_sel,
	input  wire logic [7:0] control,
	input  wire logic       sub_tick,
	// overflow pulse
	output logic            overflow
);
	import mcuic_pkg::*;
	logic [1:0]          div4_reg;
	logic                prescaler_clock;
	logic [TB_CNT_W-1:0] count_reg;
	logic [TB_CNT_W-1:0] period_mask;

	// ----------------------------------------------------------------
	// prescaler clock enable
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
		if (srst)
			div4_reg <= 2'h0;
		else
			div4_reg <= div4_reg + 2'h1;

	always_comb
		case (source_sel)
			PSC_SYS:  prescaler_clock = 1'b1;
			PSC_SYS4: prescaler_clock = (div4_reg == DIV4_LAST);
			default:  prescaler_clock = sub_tick;
		endcase

	// ----------------------------------------------------------------
	// divider, period 2^(8+code) prescaler clocks
	// ----------------------------------------------------------------
	assign period_mask = TB_CNT_W'((32'h1 << (TB_MIN_EXP + int'(control[2:0]))) - 1);

	always_ff @(posedge clk)
		if (srst || !control[TB_ON_BIT])
			count_reg <= '0;
		else if (prescaler_clock)
			count_reg <= (count_reg == period_mask) ? '0 : count_reg + 1'b1;

	assign overflow = control[TB_ON_BIT] && prescaler_clock
		&& (count_reg == period_mask);
endmodule // mcuic_timebase

// *** hw/mcuic_top.sv ***
// Behaviour
// - every source event sets its flag, regardless of its enable.
// - a source vectors only while its enable bit is high.
// - global enable low blocks every interrupt.
// - taking an interrupt pushes next pc, then loads the vector.
// - return pops the saved pc and resumes.
// - servicing clears the global enable; software may set it again.
// - flags still latch while the global enable is low.
// - a full stack blocks acknowledgement until the pointer drops.
// - any flag becoming set leaves sleep or idle.
// - wake-up comes from a flag rising, enable ignored.
// - external flag set on the selected pin edge kind.
// - one edge select setting disables the external interrupt.
// - servicing external interrupt clears its flag.
// - grouped flag set when either second compact timer flag is set.
// - servicing grouped interrupt clears only the grouped flag.
// - grouped vector needs global, timer and grouped enables.
// - each timer has A and P match flags with own enables.
// - first compact and periodic timers own vectors, flags auto-cleared.
// - touch flag set on slot counter overflow, cleared on service.
// - each time base sets its flag on overflow, cleared on service.
// - prescaler select with upper bit set picks the sub clock.
// - select 00 is system clock, 01 system clock over four.
// - period code 000..111 gives 2^8..2^15 prescaler clocks.
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module mcuic_top #(
	parameter logic [11:0] VEC_BASE = 12'h004
)(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// event sources
	input  wire logic        ext_irq_pin,
	input  wire logic        compact_timer_a_match_a,
	input  wire logic        compact_timer_a_match_p,
	input  wire logic        compact_timer_b_match_a,
	input  wire logic        compact_timer_b_match_p,
	input  wire logic        periodic_timer_match_a,
	input  wire logic        periodic_timer_match_p,
	input  wire logic        touch_slot_overflow,
	input  wire logic        sub_clock_tick,
	// core side
	input  wire logic        instr_boundary,
	input  wire logic        return_from_interrupt,
	input  wire logic        stack_full,
	input  wire logic        low_power,
	output mcuic_pkg::mcuic_core_s core,
	output logic             wake_up
);
	import mcuic_pkg::*;
	logic [NFLAG-1:0] flag_reg;
	logic [NFLAG-1:0] flag_set;
	logic [NFLAG-1:0] flag_clr;
	logic [NFLAG-1:0] enable_reg;
	logic             global_irq_enable;
	logic             grouped_irq_flag;
	logic             grouped_irq_enable;
	logic [1:0]       ext_edge_select;
	logic [1:0]       prescaler_a_source_reg;
	logic [1:0]       prescaler_b_source_reg;
	logic [7:0]       timebase_a_control;
	logic [7:0]       timebase_b_control;
	logic             pin_last_reg;
	logic             tb_a_ovf;
	logic             tb_b_ovf;
	logic [NSRC-1:0]  src_req;
	logic [NSRC-1:0]  grant;
	logic             take;
	logic             wr_en;
	mcuic_core_s      core_reg;
	logic [11:0]      last_vector_reg;

	typedef enum logic [1:0] {
		ST_RUN = 2'b01,
		ST_ISR = 2'b10
	} mcuic_state_e;
	mcuic_state_e state_reg;

	assign wr_en = psel && penable && pwrite;

	// ----------------------------------------------------------------
	// time base units
	// ----------------------------------------------------------------
	mcuic_timebase u_tb_a (
		.clk        (clk),
		.srst       (srst),
		.source_sel (prescaler_a_source_reg),
		.control    (timebase_a_control),
		.sub_tick   (sub_clock_tick),
		.overflow   (tb_a_ovf)
	);
	mcuic_timebase u_tb_b (
		.clk        (clk),
		.srst       (srst),
		.source_sel (prescaler_b_source_reg),
		.control    (timebase_b_control),
		.sub_tick   (sub_clock_tick),
		.overflow   (tb_b_ovf)
	);

	// ----------------------------------------------------------------
	// event detection
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
		if (srst)
			pin_last_reg <= 1'b0;
		else
			pin_last_reg <= ext_irq_pin;

	always_comb
	begin
		flag_set = '0;
		case (ext_edge_select)
			EDGE_RISE: flag_set[FB_EXT] = ext_irq_pin && !pin_last_reg;
			EDGE_FALL: flag_set[FB_EXT] = !ext_irq_pin && pin_last_reg;
			EDGE_BOTH: flag_set[FB_EXT] = ext_irq_pin != pin_last_reg;
			default:   flag_set[FB_EXT] = 1'b0;
		endcase
		flag_set[FB_TOUCH] = touch_slot_overflow;
		flag_set[FB_CTA_A] = compact_timer_a_match_a;
		flag_set[FB_CTA_P] = compact_timer_a_match_p;
		flag_set[FB_PT_A]  = periodic_timer_match_a;
		flag_set[FB_PT_P]  = periodic_timer_match_p;
		flag_set[FB_TBA]   = tb_a_ovf;
		flag_set[FB_TBB]   = tb_b_ovf;
		flag_set[FB_CTB_A] = compact_timer_b_match_a;
		flag_set[FB_CTB_P] = compact_timer_b_match_p;
	end

	// ----------------------------------------------------------------
	// request and priority
	// ----------------------------------------------------------------
	logic [NFLAG-1:0] fe;
	assign fe = flag_reg & enable_reg;
	assign src_req[SRC_EXT]   = fe[FB_EXT];
	assign src_req[SRC_TOUCH] = fe[FB_TOUCH];
	assign src_req[SRC_CTA]   = fe[FB_CTA_A] | fe[FB_CTA_P];
	assign src_req[SRC_PT]    = fe[FB_PT_A] | fe[FB_PT_P];
	assign src_req[SRC_TBA]   = fe[FB_TBA];
	assign src_req[SRC_TBB]   = fe[FB_TBB];
	assign src_req[SRC_GRP]   = grouped_irq_flag && grouped_irq_enable
		&& (fe[FB_CTB_A] | fe[FB_CTB_P]);

	assign grant = src_req & (~src_req + 1'b1);
	assign take  = global_irq_enable && !stack_full && instr_boundary
		&& (src_req != '0);

	// ----------------------------------------------------------------
	// flags; set wins over clear
	// ----------------------------------------------------------------
	always_comb
	begin
		flag_clr = '0;
		if (wr_en && paddr == OFS_FLAGS)
			flag_clr = ~pwdata[NFLAG-1:0];
		if (take)
		begin
			flag_clr[FB_EXT]   = flag_clr[FB_EXT] | grant[SRC_EXT];
			flag_clr[FB_TOUCH] = flag_clr[FB_TOUCH] | grant[SRC_TOUCH];
			flag_clr[FB_CTA_A] = flag_clr[FB_CTA_A] | (grant[SRC_CTA] && fe[FB_CTA_A]);
			flag_clr[FB_CTA_P] = flag_clr[FB_CTA_P]
				| (grant[SRC_CTA] && !fe[FB_CTA_A]);
			flag_clr[FB_PT_A]  = flag_clr[FB_PT_A] | (grant[SRC_PT] && fe[FB_PT_A]);
			flag_clr[FB_PT_P]  = flag_clr[FB_PT_P] | (grant[SRC_PT] && !fe[FB_PT_A]);
			flag_clr[FB_TBA]   = flag_clr[FB_TBA] | grant[SRC_TBA];
			flag_clr[FB_TBB]   = flag_clr[FB_TBB] | grant[SRC_TBB];
		end
	end

	always_ff @(posedge clk)
		if (srst)
			flag_reg <= '0;
		else
			flag_reg <= (flag_reg & ~flag_clr) | flag_set;

	always_ff @(posedge clk)
		if (srst)
			grouped_irq_flag <= 1'b0;
		else if (flag_set[FB_CTB_A] || flag_set[FB_CTB_P])
			grouped_irq_flag <= 1'b1;
		else if (take && grant[SRC_GRP])
			grouped_irq_flag <= 1'b0;
		else if (wr_en && paddr == OFS_CTRL)
			grouped_irq_flag <= pwdata[2];

	// ----------------------------------------------------------------
	// global enable
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
		if (srst)
			global_irq_enable <= 1'b0;
		else if (take)
			global_irq_enable <= 1'b0;
		else if (wr_en && paddr == OFS_CTRL)
			global_irq_enable <= pwdata[CTRL_GIE];

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
		if (srst)
		begin
			enable_reg             <= '0;
			grouped_irq_enable     <= 1'b0;
			ext_edge_select        <= EDGE_OFF;
			prescaler_a_source_reg <= PSC_SYS;
			prescaler_b_source_reg <= PSC_SYS;
			timebase_a_control     <= RST_BYTE;
			timebase_b_control     <= RST_BYTE;
		end
		else if (wr_en)
			case (paddr)
				OFS_CTRL:
				begin
					grouped_irq_enable <= pwdata[1];
					ext_edge_select    <= pwdata[5:4];
				end
				OFS_ENABLE: enable_reg             <= pwdata[NFLAG-1:0];
				OFS_PSC_A:  prescaler_a_source_reg <= pwdata[1:0];
				OFS_PSC_B:  prescaler_b_source_reg <= pwdata[1:0];
				OFS_TB_A:   timebase_a_control     <= pwdata[7:0] & 8'h87;
				OFS_TB_B:   timebase_b_control     <= pwdata[7:0] & 8'h87;
				default:    ;
			endcase

	// ----------------------------------------------------------------
	// core sequencing
	// ----------------------------------------------------------------
	logic [11:0] vec_next;
	always_comb
	begin
		vec_next = VEC_BASE;
		for (int i = NSRC - 1; i >= 0; i--)
			if (grant[i])
				vec_next = VEC_BASE + 12'(VEC_STEP * (i + 1));
	end

	always_ff @(posedge clk)
		if (srst)
		begin
			core_reg        <= '0;
			last_vector_reg <= 12'h000;
			state_reg       <= ST_RUN;
		end
		else
		begin
			core_reg.push <= take;
			core_reg.pop  <= return_from_interrupt;
			if (take)
			begin
				core_reg.vector <= vec_next;
				last_vector_reg <= vec_next;
				state_reg       <= ST_ISR;
			end
			else if (return_from_interrupt)
				state_reg <= ST_RUN;
			else
				case (state_reg)
					ST_RUN, ST_ISR: state_reg <= state_reg;
					default:        state_reg <= ST_RUN;
				endcase
		end
	assign core = core_reg;

	// ----------------------------------------------------------------
	// wake-up on flag rise
	// ----------------------------------------------------------------
	logic [NFLAG:0] flags_all_last_reg;
	always_ff @(posedge clk)
		if (srst)
		begin
			flags_all_last_reg <= '0;
			wake_up            <= 1'b0;
		end
		else
		begin
			flags_all_last_reg <= {grouped_irq_flag, flag_reg};
			wake_up <= low_power
				&& (({grouped_irq_flag, flag_reg} & ~flags_all_last_reg) != '0);
		end

	// ----------------------------------------------------------------
	// apb read path
	// ----------------------------------------------------------------
	assign pready = 1'b1;
	always_ff @(posedge clk)
		if (srst)
			pslverr <= 1'b0;
		else
			pslverr <= 1'b0;

	always_comb
	begin
		prdata = 32'h0000_0000;
		case (paddr)
			OFS_CTRL:   prdata[5:0] = {ext_edge_select, 1'b0, grouped_irq_flag,
				grouped_irq_enable, global_irq_enable};
			OFS_ENABLE: prdata[NFLAG-1:0] = enable_reg;
			OFS_FLAGS:  prdata[NFLAG-1:0] = flag_reg;
			OFS_PSC_A:  prdata[1:0] = prescaler_a_source_reg;
			OFS_PSC_B:  prdata[1:0] = prescaler_b_source_reg;
			OFS_TB_A:   prdata[7:0] = timebase_a_control;
			OFS_TB_B:   prdata[7:0] = timebase_b_control;
			OFS_VECTOR: prdata[12:0] = {state_reg == ST_ISR, last_vector_reg};
			default:    prdata = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	gie_block_a: assert property (@(posedge clk) disable iff (srst)
		!global_irq_enable |=> !core.push) else $error("push while disabled");
	stack_full_a: assert property (@(posedge clk) disable iff (srst)
		stack_full |=> !core.push) else $error("push on full stack");
	gie_clear_a: assert property (@(posedge clk) disable iff (srst)
		take |=> !global_irq_enable) else $error("global enable kept");
	boundary_a: assert property (@(posedge clk) disable iff (srst)
		!instr_boundary |=> !core.push) else $error("push mid instruction");
	ext_clear_a: assert property (@(posedge clk) disable iff (srst)
		take && grant[SRC_EXT] && !flag_set[FB_EXT] |=> !flag_reg[FB_EXT])
		else $error("external flag kept");
	grp_keep_a: assert property (@(posedge clk) disable iff (srst)
		take && grant[SRC_GRP] && !(wr_en && paddr == OFS_FLAGS)
		|=> $stable(flag_reg[FB_CTB_A]) || flag_reg[FB_CTB_A])
		else $error("grouped source flag cleared");
	set_flag_a: assert property (@(posedge clk) disable iff (srst)
		flag_set[FB_CTA_A] |=> flag_reg[FB_CTA_A]) else $error("flag lost");
	pri_a: assert property (@(posedge clk) disable iff (srst)
		take && src_req[SRC_EXT] |=> core.vector == VEC_BASE + 12'h004)
		else $error("priority wrong");
	take_c: cover property (@(posedge clk) core.push);
	grp_c:  cover property (@(posedge clk) take && grant[SRC_GRP]);
	wake_c: cover property (@(posedge clk) wake_up);
endmodule // mcuic_top

// *** tb/mcuic_core_model.sv ***
`timescale 1ns/1ps
module mcuic_core_model #(
	parameter int DEPTH = 2
)(
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   srst,
	// controller side
	input  wire mcuic_pkg::mcuic_core_s core,
	output logic                        instr_boundary,
	output logic                        return_from_interrupt,
	output logic                        stack_full,
	// bench side
	input  wire logic                   ret_req,
	output logic [1:0]                  depth
);
	import mcuic_pkg::*;
	logic [1:0]  phase_reg;
	logic [11:0] pc_reg;
	logic [11:0] stack_reg [0:3];

	// ------------------------------------------------------------
	// instruction timing and stack
	// ------------------------------------------------------------
	// every third cycle is mid-instruction
	assign instr_boundary = (phase_reg != 2'h0);
	assign stack_full     = (depth == 2'(DEPTH));
	always_ff @(posedge clk)
	begin
		if (srst || phase_reg == 2'h2)
			phase_reg <= 2'h0;
		else
			phase_reg <= phase_reg + 2'h1;
	end
	always_ff @(posedge clk)
	begin
		if (srst)
			return_from_interrupt <= 1'b0;
		else
			return_from_interrupt <= ret_req && (depth != 2'h0);
	end
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			depth  <= 2'h0;
			pc_reg <= 12'h000;
		end
		else if (core.push && !stack_full)
		begin
			stack_reg[depth] <= pc_reg;
			pc_reg           <= core.vector;
			depth            <= depth + 2'h1;
		end
		else if (core.pop && depth != 2'h0)
		begin
			pc_reg <= stack_reg[depth - 2'h1];
			depth  <= depth - 2'h1;
		end
		else if (instr_boundary)
			pc_reg <= pc_reg + 12'h001;
	end
endmodule // mcuic_core_model

// *** tb/test_mcu_interrupt_controller.sv ***
`timescale 1ns/1ps
module test_mcu_interrupt_controller;
	import mcuic_pkg::*;
	localparam logic [11:0] VB = 12'h004;
	logic        clk, srst, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic        ext_pin, sub_tick, ret_req, low_power, wake_up, bnd, rfi, full;
	logic [6:0]  ev;
	logic [1:0]  depth;
	mcuic_core_s core;
	int          fail_count, samples_checked, cyc, t0, t1;

	mcuic_top #(.VEC_BASE(VB)) mcuic_top_inst (.clk(clk), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ext_irq_pin(ext_pin),
		.compact_timer_a_match_a(ev[0]), .compact_timer_a_match_p(ev[1]),
		.compact_timer_b_match_a(ev[2]), .compact_timer_b_match_p(ev[3]),
		.periodic_timer_match_a(ev[4]), .periodic_timer_match_p(ev[5]),
		.touch_slot_overflow(ev[6]), .sub_clock_tick(sub_tick), .instr_boundary(bnd),
		.return_from_interrupt(rfi), .stack_full(full), .low_power(low_power),
		.core(core), .wake_up(wake_up));
	mcuic_core_model #(.DEPTH(2)) mcuic_core_model_inst (.clk(clk), .srst(srst), .core(core),
		.instr_boundary(bnd), .return_from_interrupt(rfi), .stack_full(full),
		.ret_req(ret_req), .depth(depth));

	// ------------------------------------------------------------
	// clock, sub clock tick every fourth cycle
	// ------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc <= srst ? 0 : cyc + 1;
		sub_tick <= !srst && (cyc % 4 == 3);
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task final_report;
		$display("mismatches %0d, checks %0d", fail_count, samples_checked);
		if (fail_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task timeout;
		fail_count++;
		$display("wait limit used up at %0t", $time);
		final_report;
	endtask
	task check32(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task check1(input logic got, input logic exp);
		check32({31'h0, got}, {31'h0, exp});
	endtask
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			timeout;
		q = prdata;
		check1(pslverr, 1'b0);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task pulse(input logic [6:0] m);
		ev <= m;
		@(posedge clk);
		ev <= 7'h00;
		@(posedge clk);
	endtask
	task expect_push(input logic [11:0] v);
		int n;
		n = 0;
		while (core.push !== 1'b1 && n < 40)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 40)
			timeout;
		check32({20'h0, core.vector}, {20'h0, v});
		@(posedge clk);
	endtask
	task expect_quiet(input logic wake);
		logic seen;
		seen = 1'b0;
		repeat (20)
		begin
			@(posedge clk);
			if ((wake ? wake_up : core.push) === 1'b1)
				seen = 1'b1;
		end
		check1(seen, 1'b0);
	endtask
	task wait_wake(input int lim, output int t);
		int n;
		n = 0;
		while (wake_up !== 1'b1 && n < lim)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= lim)
			timeout;
		t = cyc;
		@(posedge clk);
	endtask
	task do_return;
		int n;
		ret_req <= 1'b1;
		@(posedge clk);
		ret_req <= 1'b0;
		n = 0;
		while (core.pop !== 1'b1 && n < 10)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 10)
			timeout;
		@(posedge clk);
	endtask
	task tb_case(input logic [7:0] psc, input logic [7:0] tbc, input logic [1:0] sel,
		input logic [2:0] code, input int fb, input int div);
		wr(psc, {30'h0, sel});
		wr(tbc, {24'h0, 1'b1, 4'h0, code});
		wait_wake(2 * div * (1 << (TB_MIN_EXP + code)) + 40, t0);
		wr(OFS_FLAGS, 32'(10'h3FF & ~(1 << fb)));
		wait_wake(div * (1 << (TB_MIN_EXP + code)) + 40, t1);
		check32(32'(t1 - t0), 32'(div * (1 << (TB_MIN_EXP + code))));
		wr(tbc, 32'h0);
		wr(OFS_FLAGS, 32'h0);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task t_regs;
		logic [7:0] ofs [8];
		ofs = '{OFS_CTRL, OFS_ENABLE, OFS_FLAGS, OFS_PSC_A, OFS_PSC_B,
			OFS_TB_A, OFS_TB_B, OFS_VECTOR};
		foreach (ofs[i])
		begin
			apb(1'b0, ofs[i], 32'h0);
			check32(q, {24'h0, RST_BYTE});
		end
		wr(8'h40, 32'hFF);
		apb(1'b0, 8'h40, 32'h0);
		check32(q, 32'h0);
		wr(OFS_PSC_A, 32'hFF);
		apb(1'b0, OFS_PSC_A, 32'h0);
		check32(q, 32'h3);
		wr(OFS_PSC_A, 32'h0);
	endtask
	task t_enable;
		wr(OFS_CTRL, 32'h1);
		pulse(7'h10);
		expect_quiet(1'b0);
		apb(1'b0, OFS_FLAGS, 32'h0);
		check1(q[FB_PT_A], 1'b1);
		wr(OFS_CTRL, 32'h0);
		wr(OFS_ENABLE, 32'h30);
		expect_quiet(1'b0);
		pulse(7'h20);
		apb(1'b0, OFS_FLAGS, 32'h0);
		check1(q[FB_PT_P], 1'b1);
		wr(OFS_CTRL, 32'h1);
		expect_push(VB + 12'(VEC_STEP * (SRC_PT + 1)));
		apb(1'b0, OFS_CTRL, 32'h0);
		check1(q[CTRL_GIE], 1'b0);
		apb(1'b0, OFS_FLAGS, 32'h0);
		check32({30'h0, q[FB_PT_P:FB_PT_A]}, 32'h2);
		apb(1'b0, OFS_VECTOR, 32'h0);
		check32(q, {19'h0, 1'b1, VB + 12'(VEC_STEP * (SRC_PT + 1))});
		do_return;
		apb(1'b0, OFS_VECTOR, 32'h0);
		check1(q[12], 1'b0);
		wr(OFS_CTRL, 32'h1);
		expect_push(VB + 12'(VEC_STEP * (SRC_PT + 1)));
		apb(1'b0, OFS_FLAGS, 32'h0);
		check1(q[FB_PT_P], 1'b0);
		do_return;
		wr(OFS_ENABLE, 32'h0);
	endtask
	task t_priority;
		wr(OFS_ENABLE, 32'h7);
		wr(OFS_CTRL, 32'h10);
		ext_pin <= 1'b1;
		pulse(7'h40);
		wr(OFS_CTRL, 32'h11);
		expect_push(VB + 12'(VEC_STEP * (SRC_EXT + 1)));
		apb(1'b0, OFS_FLAGS, 32'h0);
		check32({30'h0, q[1:0]}, 32'h2);
		wr(OFS_CTRL, 32'h11);
		expect_push(VB + 12'(VEC_STEP * (SRC_TOUCH + 1)));
		wr(OFS_CTRL, 32'h11);
		pulse(7'h01);
		expect_quiet(1'b0);
		do_return;
		expect_push(VB + 12'(VEC_STEP * (SRC_CTA + 1)));
		do_return;
		do_return;
		check32({30'h0, depth}, 32'h0);
		ext_pin <= 1'b0;
		wr(OFS_CTRL, 32'h0);
		wr(OFS_FLAGS, 32'h0);
	endtask
	task t_edges;
		for (int e = 0; e < 4; e++)
		begin
			wr(OFS_CTRL, 32'(e << 4));
			wr(OFS_FLAGS, 32'h0);
			ext_pin <= 1'b1;
			repeat (3) @(posedge clk);
			apb(1'b0, OFS_FLAGS, 32'h0);
			check1(q[FB_EXT], e[0]);
			wr(OFS_FLAGS, 32'h0);
			ext_pin <= 1'b0;
			repeat (3) @(posedge clk);
			apb(1'b0, OFS_FLAGS, 32'h0);
			check1(q[FB_EXT], e[1]);
		end
		wr(OFS_CTRL, 32'h0);
		wr(OFS_FLAGS, 32'h0);
	endtask
	task t_group;
		wr(OFS_ENABLE, 32'(1 << FB_CTB_P));
		wr(OFS_CTRL, 32'h1);
		pulse(7'h08);
		expect_quiet(1'b0);
		apb(1'b0, OFS_CTRL, 32'h0);
		check1(q[2], 1'b1);
		wr(OFS_CTRL, 32'h7);
		expect_push(VB + 12'(VEC_STEP * (SRC_GRP + 1)));
		apb(1'b0, OFS_FLAGS, 32'h0);
		check1(q[FB_CTB_P], 1'b1);
		wr(OFS_FLAGS, 32'h0);
		do_return;
		wr(OFS_ENABLE, 32'h0);
		wr(OFS_CTRL, 32'h0);
	endtask
	task t_wake;
		low_power <= 1'b1;
		pulse(7'h40);
		wait_wake(10, t0);
		pulse(7'h40);
		expect_quiet(1'b1);
		wr(OFS_FLAGS, 32'h0);
	endtask

	initial
	begin
		{srst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
		{ext_pin, ret_req, low_power, ev} = '0;
		{fail_count, samples_checked} = '0;
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		t_regs;
		t_enable;
		t_priority;
		t_edges;
		t_group;
		t_wake;
		tb_case(OFS_PSC_A, OFS_TB_A, PSC_SYS, 3'h0, FB_TBA, 1);
		tb_case(OFS_PSC_A, OFS_TB_A, PSC_SYS4, 3'h0, FB_TBA, 4);
		tb_case(OFS_PSC_A, OFS_TB_A, PSC_SYS, 3'h1, FB_TBA, 1);
		tb_case(OFS_PSC_A, OFS_TB_A, 2'h2, 3'h0, FB_TBA, 4);
		tb_case(OFS_PSC_A, OFS_TB_A, 2'h3, 3'h0, FB_TBA, 4);
		tb_case(OFS_PSC_B, OFS_TB_B, PSC_SYS, 3'h7, FB_TBB, 1);
		final_report;
	end
endmodule // test_mcu_interrupt_controller
